// ---- logic/smp_array.sv ----
// Sum-of-products macrocell array with its APB configuration slave.
// Assumes pins and dedicated inputs are asynchronous to pclk and that
// software writes the configuration before relying on the pins.
//
// Overview of operation
// - Eight terms per macrocell, one for enable
// - Enable term drives the pin tri-state buffer
// - Terms pick true or complement of signals
// - Registered or combinatorial chosen per macrocell
// - Registered feedback comes from the register
// - Combinatorial feedback comes from the pin
// - All eight pins offer pin feedback when combinatorial
// - Register captures on global clock rising edge
// - Polarity XOR passes or inverts the sum
// - Enable term always-on or shared input
// - Pins act as input, output or bidirectional
// - Eight pins plus ten or fourteen inputs
// - Macrocell registers start low
//
// The APB slave port and the register addresses were left to the implementer.
module smp_array
    import smp_pkg::*;
#(
    parameter int NUM_DED = NUM_DED_SMALL
)
(
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [ADDR_W-1:0]  paddr,
    input  wire logic [31:0]        pwdata,
    input  wire logic [3:0]         pstrb,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    input  wire logic [NUM_DED-1:0] ded_in,
    input  wire logic [NUM_MC-1:0]  pin_in,
    output logic      [NUM_MC-1:0]  pin_out,
    output logic      [NUM_MC-1:0]  pin_oe_n
);

    localparam int NSIG = NUM_DED + NUM_MC;
    localparam int NLIT = 2 * NSIG;

    // Configuration state
    logic [31:0]  mask_r [0:MASK_WORDS-1];
    smp_ctrl_type ctrl_r;

    // Synchronisers for all asynchronous inputs
    logic [NSIG-1:0] async_in;
    logic [NSIG-1:0] sync1_r;
    logic [NSIG-1:0] sync2_r;
    logic [NSIG-1:0] sync3_r;
    logic [NSIG-1:0] lvl_r;
    logic [NSIG-1:0] lvl_nxt;
    logic [NUM_DED-1:0] ded_lvl;
    logic [NUM_MC-1:0]  pin_lvl;

    // Global clock edge, taken from dedicated input 0
    logic gclk_rise;

    // Array signals
    logic [NSIG-1:0]   sig;
    logic [NLIT-1:0]   lit;
    logic [NUM_MC-1:0] fb;
    logic [NUM_MC-1:0] sum_val;
    logic [NUM_MC-1:0] oe_val;
    logic [NUM_MC-1:0] mreg_r;
    logic [NUM_MC-1:0] mreg_nxt;
    logic [NUM_MC-1:0] pin_out_r;
    logic [NUM_MC-1:0] pin_oe_n_r;

    // Bus signals
    logic        setup_cyc;
    logic        wr_take;
    logic        in_mask;
    logic        addr_ok;
    logic [31:0] rd_nxt;
    logic [31:0] prdata_r;
    logic        pready_r;
    logic        pslverr_r;
    logic [6:0]  widx;
    logic [31:0] din_word;
    logic [31:0] ctrl_wr;

    assign async_in = {pin_in, ded_in};

    // Three stages; a new level counts only once stages two and three agree
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync1_r <= '0;
            sync2_r <= '0;
            sync3_r <= '0;
        end
        else
        begin
            sync1_r <= async_in;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
        end
    end

    generate
        for (genvar k = 0; k < NSIG; k++)
        begin : g_lvl
            assign lvl_nxt[k] = (sync2_r[k] == sync3_r[k]) ? sync3_r[k] : lvl_r[k];
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lvl_r <= '0;
        end
        else
        begin
            lvl_r <= lvl_nxt;
        end
    end

    assign ded_lvl = lvl_r[NUM_DED-1:0];
    assign pin_lvl = lvl_r[NSIG-1:NUM_DED];

    // Dedicated input 0 is both an array input and the global clock
    assign gclk_rise = lvl_nxt[0] & ~lvl_r[0];

    // Feedback choice per macrocell
    generate
        for (genvar m = 0; m < NUM_MC; m++)
        begin : g_fb
            assign fb[m] = ctrl_r.regmode[m] ? mreg_r[m] : pin_lvl[m];
        end
    endgenerate

    assign sig = {fb, ded_lvl};

    generate
        for (genvar k = 0; k < NSIG; k++)
        begin : g_lit
            assign lit[2*k]   = sig[k];
            assign lit[2*k+1] = ~sig[k];
        end
    endgenerate

    // Macrocells, each with its own slice of the mask store
    generate
        for (genvar m = 0; m < NUM_MC; m++)
        begin : g_mc
            logic [NUM_TERMS*NLIT-1:0] tmask;
            for (genvar t = 0; t < NUM_TERMS; t++)
            begin : g_term
                logic [63:0] pair;
                assign pair = {mask_r[(m*NUM_TERMS+t)*WORDS_PER_TERM+1],
                               mask_r[(m*NUM_TERMS+t)*WORDS_PER_TERM]};
                assign tmask[t*NLIT +: NLIT] = pair[NLIT-1:0];
            end
            smp_macrocell #(
                .NLIT  (NLIT),
                .NTERM (NUM_TERMS)
            ) u_mc (
                .lit       (lit),
                .term_mask (tmask),
                .invert    (ctrl_r.invert[m]),
                .sum_val   (sum_val[m]),
                .oe_val    (oe_val[m])
            );
        end
    endgenerate

    // Registers capture post-XOR value on each global clock rise
    assign mreg_nxt = gclk_rise ? sum_val : mreg_r;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mreg_r <= '0;
        end
        else
        begin
            mreg_r <= mreg_nxt;
        end
    end

    // Pins are retimed by one pclk so that every output leaves a flop;
    // combinatorial mode therefore lags the synchronised levels by one pclk.
    generate
        for (genvar m = 0; m < NUM_MC; m++)
        begin : g_pin
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    pin_out_r[m]  <= 1'b0;
                    pin_oe_n_r[m] <= 1'b1;
                end
                else
                begin
                    pin_out_r[m]  <= ctrl_r.regmode[m] ? mreg_nxt[m] : sum_val[m];
                    pin_oe_n_r[m] <= ~oe_val[m];
                end
            end
        end
    endgenerate

    assign pin_out  = pin_out_r;
    assign pin_oe_n = pin_oe_n_r;

    // APB: zero wait states, answer prepared in the setup cycle
    assign setup_cyc = psel & ~penable;
    assign wr_take   = psel & penable & pready_r & pwrite;
    assign in_mask   = (paddr[ADDR_W-1:9] == MASK_BASE[ADDR_W-1:9]);
    assign widx      = paddr[8:2];
    assign addr_ok   = in_mask | (paddr == CTRL_ADDR) | (paddr == STAT_ADDR)
                     | (paddr == DIN_ADDR);

    function automatic logic [31:0] merge(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0]  strb
    );
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++)
        begin
            if (strb[b])
            begin
                res[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return res;
    endfunction : merge

    // Merged in full width; only the low half is kept as control state
    assign ctrl_wr = merge({16'h0000, ctrl_r}, pwdata, pstrb);

    always_comb
    begin
        din_word = '0;
        din_word[NUM_DED-1:0] = ded_lvl;
    end

    always_comb
    begin
        rd_nxt = '0;
        if (in_mask)
        begin
            rd_nxt = mask_r[widx];
        end
        else if (paddr == CTRL_ADDR)
        begin
            rd_nxt[CTRL_WIDTH-1:0] = ctrl_r;
        end
        else if (paddr == STAT_ADDR)
        begin
            rd_nxt[STAT_PIN_LSB +: NUM_MC]  = pin_lvl;
            rd_nxt[STAT_MREG_LSB +: NUM_MC] = mreg_r;
            rd_nxt[STAT_OE_LSB +: NUM_MC]   = ~pin_oe_n_r;
        end
        else if (paddr == DIN_ADDR)
        begin
            rd_nxt = din_word;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_r  <= '0;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end
        else
        begin
            pready_r  <= setup_cyc;
            pslverr_r <= setup_cyc & ~addr_ok;
            if (setup_cyc)
            begin
                prdata_r <= pwrite ? 32'h0000_0000 : rd_nxt;
            end
        end
    end

    assign prdata  = prdata_r;
    assign pready  = pready_r;
    assign pslverr = pslverr_r;

    // Configuration is meant to be loaded before use; changing it live
    // glitches the array, which is accepted to keep the store simple.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < MASK_WORDS; i++)
            begin
                mask_r[i] <= MASK_RESET;
            end
        end
        else if (wr_take && in_mask)
        begin
            mask_r[widx] <= merge(mask_r[widx], pwdata, pstrb);
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_r <= CTRL_RESET;
        end
        else if (wr_take && paddr == CTRL_ADDR)
        begin
            ctrl_r <= ctrl_wr[CTRL_WIDTH-1:0];
        end
    end

endmodule : smp_array

// ---- logic/smp_macrocell.sv ----
// One macrocell: product terms, OR, polarity XOR and the enable term.
// Assumes the literal vector holds true/complement pairs of every signal.
module smp_macrocell
    import smp_pkg::*;
#(
    parameter int NLIT   = 36,
    parameter int NTERM  = NUM_TERMS
)
(
    input  wire logic [NLIT-1:0]       lit,
    input  wire logic [NTERM*NLIT-1:0] term_mask,
    input  wire logic                  invert,
    output logic                       sum_val,
    output logic                       oe_val
);

    logic [NTERM-1:0] term;
    logic             sum_or;

    // A term with no connection at all is true: this is how the enable
    // term holds the pin permanently driven.
    always_comb
    begin
        for (int t = 0; t < NTERM; t++)
        begin
            term[t] = &(~term_mask[t*NLIT +: NLIT] | lit);
        end
    end

    always_comb
    begin
        sum_or = 1'b0;
        for (int t = 0; t < NTERM; t++)
        begin
            if (t != OE_TERM)
            begin
                sum_or = sum_or | term[t];
            end
        end
    end

    assign sum_val = sum_or ^ invert;
    assign oe_val  = term[OE_TERM];

endmodule : smp_macrocell

// ---- logic/smp_pkg.sv ----
// Constants and types shared by the sum-of-products macrocell array.
// Assumes a single pclk domain and APB register access.
package smp_pkg;

    // Array geometry
    localparam int NUM_MC          = 8;
    localparam int NUM_TERMS       = 8;
    localparam int NUM_DED_SMALL   = 10;
    localparam int NUM_DED_LARGE   = 14;
    localparam int OE_TERM         = NUM_TERMS - 1;
    localparam int WORDS_PER_TERM  = 2;
    localparam int MASK_WORDS      = NUM_MC * NUM_TERMS * WORDS_PER_TERM;

    // Pin synchroniser depth
    localparam int SYNC_STAGES     = 3;

    // APB map, byte addresses
    localparam int          ADDR_W      = 12;
    localparam logic [11:0] MASK_BASE   = 12'h000;
    localparam logic [11:0] CTRL_ADDR   = 12'h200;
    localparam logic [11:0] STAT_ADDR   = 12'h204;
    localparam logic [11:0] DIN_ADDR    = 12'h208;

    // Control register fields
    localparam int CTRL_REGMODE_LSB = 0;
    localparam int CTRL_INVERT_LSB  = 8;
    localparam int CTRL_WIDTH       = 16;

    // Status register fields
    localparam int STAT_PIN_LSB     = 0;
    localparam int STAT_MREG_LSB    = 8;
    localparam int STAT_OE_LSB      = 16;

    // Reset values: every literal connected makes every term false,
    // so pins come out of reset undriven.
    localparam logic [31:0] MASK_RESET  = 32'hFFFF_FFFF;
    localparam logic [15:0] CTRL_RESET  = 16'h0000;

    // Per-macrocell configuration carried as one word
    typedef struct packed {
        logic [NUM_MC-1:0] invert;
        logic [NUM_MC-1:0] regmode;
    } smp_ctrl_type;

endpackage : smp_pkg

// ---- tb/smp_array_monitor.sv ----
// Port checker for smp_array: APB answers, reset state, pin stability.
// Assumes one pclk domain with asynchronous active-low presetn.
module smp_array_monitor
    import smp_pkg::*;
#(
    parameter int NUM_DED = NUM_DED_SMALL
)
(
    input wire logic               pclk,
    input wire logic               presetn,
    input wire logic               psel,
    input wire logic               penable,
    input wire logic               pwrite,
    input wire logic [ADDR_W-1:0]  paddr,
    input wire logic [31:0]        prdata,
    input wire logic               pready,
    input wire logic               pslverr,
    input wire logic [NUM_DED-1:0] ded_in,
    input wire logic [NUM_MC-1:0]  pin_in,
    input wire logic [NUM_MC-1:0]  pin_out,
    input wire logic [NUM_MC-1:0]  pin_oe_n
);
    // Quiet cycles: no bus access, no input change; pins settle within 6
    logic [3:0]         quiet_r;
    logic [NUM_MC-1:0]  pin_q_r;
    logic [NUM_DED-1:0] ded_q_r;

    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            quiet_r <= 4'h0;
            pin_q_r <= '0;
            ded_q_r <= '0;
        end
        else
        begin
            pin_q_r <= pin_in;
            ded_q_r <= ded_in;
            if (psel || pin_in != pin_q_r || ded_in != ded_q_r)
                quiet_r <= 4'h0;
            else if (quiet_r != 4'h8)
                quiet_r <= quiet_r + 4'h1;
        end
    end

    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_ready_in_access: assert property (pready |-> psel && penable)
        else $error("ready outside access");
    a_error_no_data: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("bad error response");
    a_write_no_data: assert property (pready && pwrite |-> prdata == 32'h0)
        else $error("read data on a write");
    a_unmapped_error: assert property (pready && paddr > 12'h208 |-> pslverr)
        else $error("unmapped address not refused");
    a_pins_reset: assert property ($rose(presetn) |-> &pin_oe_n && pin_out == 8'h00)
        else $error("pins not released by reset");
    a_pins_quiet: assert property (quiet_r >= 4'h7 |-> $stable(pin_out)
        && $stable(pin_oe_n))
        else $error("pins moved with inputs quiet");
endmodule : smp_array_monitor

bind smp_array smp_array_monitor #(.NUM_DED(NUM_DED)) smp_array_monitor_i (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .ded_in, .pin_in,
    .pin_out, .pin_oe_n);

// ---- tb/smp_array_tb.sv ----
// Self-checking bench for smp_array, small variant, configured over APB.
// Pin levels are resolved here from the device enable and the bench drive.
module smp_array_tb
    import smp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic                     pclk = 1'b0, presetn = 1'b0, psel = 1'b0;
    logic                     penable = 1'b0, pwrite = 1'b0, pready, pslverr, e;
    logic [ADDR_W-1:0]        paddr = 12'h000;
    logic [31:0]              pwdata = 32'h0, prdata, q;
    logic [3:0]               pstrb = 4'hF;
    logic [NUM_DED_SMALL-1:0] ded_in = 10'h000;
    logic [NUM_MC-1:0]        ext_drv = 8'h00, pin_in, pin_out, pin_oe_n;
    int                       n_mismatch = 0, check_count = 0;

    always #12.5 pclk = ~pclk;
    assign pin_in = (pin_out & ~pin_oe_n) | (ext_drv & pin_oe_n);

    smp_array #(.NUM_DED(NUM_DED_SMALL)) smp_array_i (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .ded_in, .pin_in,
        .pin_out, .pin_oe_n);

    task automatic test_done;
        $display("Checks %0d, mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : test_done

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Request held until pready is seen high; released one edge before return
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
        begin
            n++;
            if (n > 16)
            begin
                n_mismatch++;
                test_done();
            end
            @(posedge pclk);
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic term(input int mc, input int t, input logic [31:0] lo, input logic [31:0] hi);
        apb(1'b1, 12'((mc * 8 + t) * 8), lo);
        apb(1'b1, 12'((mc * 8 + t) * 8 + 4), hi);
    endtask : term

    // Margin over the five-edge input path
    task automatic settle;
        repeat (8) @(posedge pclk);
    endtask : settle

    initial
    begin
        int          c;
        logic [63:0] w;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check(32'({pin_oe_n, pin_out}), 32'h0000_FF00);
        apb(1'b0, CTRL_ADDR, 32'h0);
        check(q, 32'h0);
        apb(1'b0, MASK_BASE + 12'h1FC, 32'h0);
        check(q, MASK_RESET);
        apb(1'b0, 12'h20C, 32'h0);
        check({q[30:0], e}, 32'h1);
        // Each pin, left undriven, feeds the next macrocell
        for (int m = 0; m < NUM_MC; m++)
        begin
            c = (m + 1) % NUM_MC;
            w = 64'h1 << (2 * (NUM_DED_SMALL + m));
            term(c, OE_TERM, 32'h0, 32'h0);
            term(c, 0, w[31:0], w[63:32]);
            for (int v = 0; v < 2; v++)
            begin
                ext_drv[m] <= v[0];
                settle();
                check(32'({pin_oe_n[m], pin_out[c]}), 32'({1'b1, v[0]}));
            end
            term(c, 0, MASK_RESET, MASK_RESET);
            term(c, OE_TERM, MASK_RESET, MASK_RESET);
        end
        term(0, OE_TERM, 32'h0, 32'h0);
        term(0, 0, 32'h4, 32'h0);
        term(0, 1, 32'h10, 32'h0);
        for (int v = 0; v < 8; v++)
        begin
            ded_in[2:1] <= v[1:0];
            apb(1'b1, CTRL_ADDR, 32'(v[2]) << 8);
            settle();
            check(32'(pin_out[0]), 32'((v[0] | v[1]) ^ v[2]));
        end
        // Complement literal, enable shared from an input
        term(1, 0, 32'h20, 32'h0);
        term(1, OE_TERM, 32'h40, 32'h0);
        for (int v = 0; v < 4; v++)
        begin
            ded_in[3:2] <= v[1:0];
            settle();
            check(32'(pin_oe_n[1]), 32'(!v[1]));
            if (v[1])
                check(32'(pin_out[1]), 32'(!v[0]));
        end
        // Inputs 1 to 3 are high and input 0 low by now
        apb(1'b0, DIN_ADDR, 32'h0);
        check(q, 32'h0000_000E);
        // Macrocell 4 registered as a toggle on its own feedback
        term(4, OE_TERM, 32'h0, 32'h0);
        term(4, 0, 32'h2000_0000, 32'h0);
        apb(1'b1, CTRL_ADDR, 32'h0000_0010);
        settle();
        check(32'({pin_out[4], pin_out[0]}), 32'h1);
        for (int k = 1; k <= 4; k++)
        begin
            ded_in[0] <= 1'b1;
            repeat (4) @(posedge pclk);
            ded_in[0] <= 1'b0;
            settle();
            check(32'(pin_out[4]), 32'(k[0]));
        end
        // Pin released and held high: a pin-fed toggle would stick low
        term(4, OE_TERM, MASK_RESET, MASK_RESET);
        ext_drv[4] <= 1'b1;
        ded_in[0] <= 1'b1;
        settle();
        apb(1'b0, STAT_ADDR, 32'h0);
        check(32'(q[STAT_MREG_LSB + 4]), 32'h1);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check(32'({pin_oe_n, pin_out}), 32'h0000_FF00);
        test_done();
    end
endmodule : smp_array_tb
